// ### rtl/cscr_pkg.sv
// constants shared by the clock source control block
package cscr_pkg;

  // ----------------------------------------
  // bus and field sizes
  // ----------------------------------------
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int N_EV = 4;
  localparam int SRC_W = 2;
  localparam int CT_IVL_W = 7;

  // ----------------------------------------
  // register byte offsets
  // ----------------------------------------
  localparam logic [ADDR_W-1:0] OFF_FAST_START = 12'h000;
  localparam logic [ADDR_W-1:0] OFF_FAST_STOP = 12'h004;
  localparam logic [ADDR_W-1:0] OFF_SLOW_START = 12'h008;
  localparam logic [ADDR_W-1:0] OFF_SLOW_STOP = 12'h00C;
  localparam logic [ADDR_W-1:0] OFF_CAL = 12'h010;
  localparam logic [ADDR_W-1:0] OFF_CT_START = 12'h014;
  localparam logic [ADDR_W-1:0] OFF_CT_STOP = 12'h018;
  localparam logic [ADDR_W-1:0] EV_OFF [N_EV] = '{12'h100, 12'h104, 12'h10C, 12'h110};
  localparam logic [ADDR_W-1:0] OFF_IEN_SET = 12'h304;
  localparam logic [ADDR_W-1:0] OFF_IEN_CLR = 12'h308;
  localparam logic [ADDR_W-1:0] OFF_FAST_RUN = 12'h408;
  localparam logic [ADDR_W-1:0] OFF_FAST_STAT = 12'h40C;
  localparam logic [ADDR_W-1:0] OFF_SLOW_RUN = 12'h414;
  localparam logic [ADDR_W-1:0] OFF_SLOW_STAT = 12'h418;
  localparam logic [ADDR_W-1:0] OFF_SRC_COPY = 12'h41C;
  localparam logic [ADDR_W-1:0] OFF_SRC_SEL = 12'h518;
  localparam logic [ADDR_W-1:0] OFF_CT_IVL = 12'h538;

  // ----------------------------------------
  // event indices and field positions
  // ----------------------------------------
  localparam int EV_FAST = 0;
  localparam int EV_SLOW = 1;
  localparam int EV_DONE = 2;
  localparam int EV_CT_TIMEOUT = 3;
  localparam int STAT_STATE_BIT = 16;
  localparam int SEL_BYPASS_BIT = 16;
  localparam int SEL_EXT_BIT = 17;
  localparam logic [SRC_W-1:0] SRC_RC = 2'h0;
  localparam logic [SRC_W-1:0] SRC_XTAL = 2'h1;
  localparam logic [SRC_W-1:0] SRC_SYNTH = 2'h2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_HZ = 50_000_000;
  localparam int MS_PER_S = 1000;
  localparam int CT_UNIT_MS = 250;
  localparam int CT_UNIT_CYC = CLK_HZ / MS_PER_S * CT_UNIT_MS;

endpackage

// ### rtl/cscr_ct_if.sv
// link between the register block and the calibration timer
`timescale 1ns/1ps
`default_nettype none
interface cscr_ct_if
  import cscr_pkg::*;
();
  logic start;
  logic stop;
  logic [CT_IVL_W-1:0] interval;
  logic timeout;
  logic running;
  modport ctl(output start, output stop, output interval, input timeout, input running);
  modport tmr(input start, input stop, input interval, output timeout, output running);
endinterface
`default_nettype wire

// ### rtl/cscr_cal_timer.sv
// calibration timer: counts down interval units, then times out
`timescale 1ns/1ps
`default_nettype none
module cscr_cal_timer
  import cscr_pkg::*;
#(
  parameter int UNIT_CYCLES = CT_UNIT_CYC, // clocks per interval unit
  parameter int DIV_W = 24 // unit divider width
) (
  input wire logic clk, // clock
  input wire logic rst_n, // synchronised reset
  cscr_ct_if.tmr ct // control and timeout
);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(UNIT_CYCLES - 1);
  logic [DIV_W-1:0] div;
  logic [CT_IVL_W-1:0] cnt;
  logic tick;

  assign tick = div == DIV_LAST;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div <= '0;
      cnt <= '0;
      ct.running <= 1'b0;
      ct.timeout <= 1'b0;
    end else begin
      ct.timeout <= 1'b0;
      if (ct.start) begin
        ct.running <= 1'b1;
        cnt <= ct.interval;
        div <= '0;
      end else if (ct.stop) begin
        ct.running <= 1'b0;
      end else if (ct.running) begin
        if (cnt == '0) begin
          ct.running <= 1'b0;
          ct.timeout <= 1'b1;
        end else if (tick) begin
          div <= '0;
          cnt <= cnt - 1'b1;
        end else begin
          div <= div + 1'b1;
        end
      end
    end
  end

  property p_ct_zero;
    @(posedge clk) disable iff (!rst_n)
    ct.running && cnt == '0 && !ct.start && !ct.stop |=> ct.timeout && !ct.running;
  endproperty
  a_ct_zero: assert property (p_ct_zero)
    else $error("timer did not stop with timeout at zero");
endmodule
`default_nettype wire

// ### rtl/cscr_slow_ctl.sv
// slow clock sequencer: for the crystal, rc first, then crystal when it oscillates; other sources start at once
`timescale 1ns/1ps
`default_nettype none
module cscr_slow_ctl
  import cscr_pkg::*;
(
  input wire logic clk, // clock
  input wire logic rst_n, // synchronised reset
  input wire logic start, // start pulse
  input wire logic stop, // stop pulse
  input wire logic [SRC_W-1:0] src, // selected source
  input wire logic xtal_ok, // crystal oscillates
  output logic running, // slow clock running
  output logic [SRC_W-1:0] cur_src, // source now in use
  output logic started // started event pulse
);
  typedef enum logic [1:0] {SL_IDLE, SL_WAIT_XTAL, SL_RUN} cscr_slow_e;
  cscr_slow_e state;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= SL_IDLE;
      running <= 1'b0;
      cur_src <= SRC_RC;
      started <= 1'b0;
    end else begin
      started <= 1'b0;
      unique case (state)
        SL_IDLE: begin
          if (start) begin
            running <= 1'b1;
            if (src == SRC_XTAL) begin
              state <= SL_WAIT_XTAL;
              cur_src <= SRC_RC;
            end else begin
              state <= SL_RUN;
              cur_src <= src;
              started <= 1'b1;
            end
          end
        end
        SL_WAIT_XTAL: begin
          if (stop) begin
            state <= SL_IDLE;
            running <= 1'b0;
          end else if (xtal_ok) begin
            state <= SL_RUN;
            cur_src <= SRC_XTAL;
            started <= 1'b1;
          end
        end
        SL_RUN: begin
          if (stop) begin
            state <= SL_IDLE;
            running <= 1'b0;
          end
        end
      endcase
    end
  end

  property p_xtal_switch;
    @(posedge clk) disable iff (!rst_n)
    state == SL_WAIT_XTAL && xtal_ok && !stop |=> started && cur_src == SRC_XTAL;
  endproperty
  a_xtal_switch: assert property (p_xtal_switch)
    else $error("no switch to crystal after it started");
endmodule
`default_nettype wire

// ### rtl/cscr_regs.sv
// clock source control: register file, triggers, events, interrupt
//
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module cscr_regs
  import cscr_pkg::*;
#(
  parameter int CT_UNIT_CYCLES = CT_UNIT_CYC, // clocks per timer unit
  parameter int CT_DIV_W = 24 // timer divider width
) (
  input wire logic clk, // clock
  input wire logic nrst, // async reset, low
  input wire logic [ADDR_W-1:0] s_awaddr, // write address
  input wire logic s_awvalid, // write address valid
  output logic s_awready, // write address ready
  input wire logic [DATA_W-1:0] s_wdata, // write data
  input wire logic [3:0] s_wstrb, // byte strobes
  input wire logic s_wvalid, // write data valid
  output logic s_wready, // write data ready
  output logic [1:0] s_bresp, // write response
  output logic s_bvalid, // write response valid
  input wire logic s_bready, // write response ready
  input wire logic [ADDR_W-1:0] s_araddr, // read address
  input wire logic s_arvalid, // read address valid
  output logic s_arready, // read address ready
  output logic [DATA_W-1:0] s_rdata, // read data
  output logic [1:0] s_rresp, // read response
  output logic s_rvalid, // read data valid
  input wire logic s_rready, // read data ready
  input wire logic fast_xtal_ok, // fast crystal oscillates
  input wire logic slow_xtal_ok, // slow crystal oscillates
  input wire logic cal_ack, // calibration finished
  output logic fast_xtal_en, // fast crystal requested
  output logic slow_rc_en, // slow rc oscillator on
  output logic slow_xtal_en, // slow crystal oscillator on
  output logic slow_synth_en, // slow synthesizer on
  output logic slow_bypass, // crystal bypass
  output logic slow_external, // external slow source
  output logic cal_req, // calibration in progress
  output logic irq // interrupt, high
);

  // ----------------------------------------
  // reset release
  // ----------------------------------------
  logic rst_q1;
  logic rst_n;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_q1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_n <= rst_q1;
    end
  end

  // ----------------------------------------
  // bus handshake
  // ----------------------------------------
  logic [ADDR_W-1:0] aw_addr;
  logic [ADDR_W-1:0] ar_addr;
  logic [DATA_W-1:0] wd;
  logic [3:0] ws;
  logic aw_take;
  logic w_take;
  logic b_take;
  logic ar_take;
  logic r_take;
  logic do_wr;
  logic do_rd;
  logic [DATA_W-1:0] rd_mux;

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    return a inside {OFF_FAST_START, OFF_FAST_STOP, OFF_SLOW_START,
      OFF_SLOW_STOP, OFF_CAL, OFF_CT_START, OFF_CT_STOP, EV_OFF[EV_FAST],
      EV_OFF[EV_SLOW], EV_OFF[EV_DONE], EV_OFF[EV_CT_TIMEOUT], OFF_IEN_SET,
      OFF_IEN_CLR, OFF_FAST_RUN, OFF_FAST_STAT, OFF_SLOW_RUN, OFF_SLOW_STAT,
      OFF_SRC_COPY, OFF_SRC_SEL, OFF_CT_IVL};
  endfunction

  assign aw_take = s_awvalid & s_awready;
  assign w_take = s_wvalid & s_wready;
  assign b_take = s_bvalid & s_bready;
  assign ar_take = s_arvalid & s_arready;
  assign r_take = s_rvalid & s_rready;
  assign do_wr = !s_awready & !s_wready & !s_bvalid;
  assign do_rd = !s_arready & !s_rvalid;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_awready <= 1'b1;
      aw_addr <= '0;
    end else if (aw_take) begin
      s_awready <= 1'b0;
      aw_addr <= s_awaddr;
    end else if (b_take) begin
      s_awready <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_wready <= 1'b1;
      wd <= '0;
      ws <= '0;
    end else if (w_take) begin
      s_wready <= 1'b0;
      wd <= s_wdata;
      ws <= s_wstrb;
    end else if (b_take) begin
      s_wready <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_bvalid <= 1'b0;
      s_bresp <= RESP_OKAY;
    end else if (do_wr) begin
      s_bvalid <= 1'b1;
      s_bresp <= mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
    end else if (b_take) begin
      s_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_arready <= 1'b1;
      ar_addr <= '0;
    end else if (ar_take) begin
      s_arready <= 1'b0;
      ar_addr <= s_araddr;
    end else if (r_take) begin
      s_arready <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_rvalid <= 1'b0;
      s_rdata <= '0;
      s_rresp <= RESP_OKAY;
    end else if (do_rd) begin
      s_rvalid <= 1'b1;
      s_rdata <= rd_mux;
      s_rresp <= mapped(ar_addr) ? RESP_OKAY : RESP_SLVERR;
    end else if (r_take) begin
      s_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------
  // write decode
  // ----------------------------------------
  logic w_trig;
  logic wr_fast_start;
  logic wr_fast_stop;
  logic wr_slow_start;
  logic wr_slow_stop;
  logic wr_cal;
  logic wr_ien_set;
  logic wr_ien_clr;
  logic wr_sel;
  logic wr_ivl;

  assign w_trig = do_wr & ws[0] & wd[0];
  assign wr_fast_start = w_trig & (aw_addr == OFF_FAST_START);
  assign wr_fast_stop = w_trig & (aw_addr == OFF_FAST_STOP);
  assign wr_slow_start = w_trig & (aw_addr == OFF_SLOW_START);
  assign wr_slow_stop = w_trig & (aw_addr == OFF_SLOW_STOP);
  assign wr_cal = w_trig & (aw_addr == OFF_CAL);
  assign wr_ien_set = do_wr & ws[0] & (aw_addr == OFF_IEN_SET);
  assign wr_ien_clr = do_wr & ws[0] & (aw_addr == OFF_IEN_CLR);
  assign wr_sel = do_wr & (aw_addr == OFF_SRC_SEL);
  assign wr_ivl = do_wr & ws[0] & (aw_addr == OFF_CT_IVL);

  // ----------------------------------------
  // calibration timer
  // ----------------------------------------
  logic [CT_IVL_W-1:0] ct_ivl;
  cscr_ct_if ct();

  assign ct.start = w_trig & (aw_addr == OFF_CT_START);
  assign ct.stop = w_trig & (aw_addr == OFF_CT_STOP);
  assign ct.interval = ct_ivl;

  cscr_cal_timer #(
    .UNIT_CYCLES(CT_UNIT_CYCLES),
    .DIV_W(CT_DIV_W)
  ) u_timer (
    .clk(clk),
    .rst_n(rst_n),
    .ct(ct.tmr)
  );

  // ----------------------------------------
  // configuration and run state
  // ----------------------------------------
  logic [SRC_W-1:0] src_sel;
  logic [SRC_W-1:0] src_snap;
  logic slow_req;
  logic fast_ok_q;
  logic slow_run;
  logic slow_started;
  logic [SRC_W-1:0] slow_cur;

  // source may change at any time; software keeps it steady while running
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      src_sel <= SRC_RC;
      slow_bypass <= 1'b0;
      slow_external <= 1'b0;
      ct_ivl <= '0;
    end else begin
      if (wr_sel && ws[0]) begin
        src_sel <= wd[SRC_W-1:0];
      end
      if (wr_sel && ws[2]) begin
        slow_bypass <= wd[SEL_BYPASS_BIT];
        slow_external <= wd[SEL_EXT_BIT];
      end
      if (wr_ivl) begin
        ct_ivl <= wd[CT_IVL_W-1:0];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fast_xtal_en <= 1'b0;
      fast_ok_q <= 1'b0;
      slow_req <= 1'b0;
      src_snap <= SRC_RC;
      cal_req <= 1'b0;
    end else begin
      if (wr_fast_start) begin
        fast_xtal_en <= 1'b1;
      end else if (wr_fast_stop) begin
        fast_xtal_en <= 1'b0;
      end
      fast_ok_q <= fast_xtal_en & fast_xtal_ok;
      if (wr_slow_start) begin
        slow_req <= 1'b1;
        src_snap <= src_sel;
      end else if (wr_slow_stop) begin
        slow_req <= 1'b0;
      end
      if (wr_cal) begin
        cal_req <= 1'b1;
      end else if (cal_ack) begin
        cal_req <= 1'b0;
      end
    end
  end

  // stop is only issued after status shows running
  cscr_slow_ctl u_slow (
    .clk(clk),
    .rst_n(rst_n),
    .start(wr_slow_start),
    .stop(wr_slow_stop),
    .src(src_sel),
    .xtal_ok(slow_xtal_ok),
    .running(slow_run),
    .cur_src(slow_cur),
    .started(slow_started)
  );

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      slow_rc_en <= 1'b0;
      slow_xtal_en <= 1'b0;
      slow_synth_en <= 1'b0;
    end else begin
      slow_rc_en <= slow_run & (slow_cur == SRC_RC);
      slow_xtal_en <= slow_req & (src_snap == SRC_XTAL);
      slow_synth_en <= slow_run & (slow_cur == SRC_SYNTH);
    end
  end

  // ----------------------------------------
  // events and interrupt
  // ----------------------------------------
  logic [N_EV-1:0] ev;
  logic [N_EV-1:0] ev_set;
  logic [N_EV-1:0] ien;

  assign ev_set[EV_FAST] = fast_xtal_en & fast_xtal_ok & !fast_ok_q;
  assign ev_set[EV_SLOW] = slow_started;
  assign ev_set[EV_DONE] = cal_req & cal_ack;
  assign ev_set[EV_CT_TIMEOUT] = ct.timeout;

  // a read or a zero write clears; a new event in that cycle wins
  for (genvar i = 0; i < N_EV; i++) begin : g_ev
    logic clr;
    assign clr = (do_rd & (ar_addr == EV_OFF[i])) |
      (do_wr & ws[0] & !wd[0] & (aw_addr == EV_OFF[i]));
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        ev[i] <= 1'b0;
      end else if (ev_set[i]) begin
        ev[i] <= 1'b1;
      end else if (clr) begin
        ev[i] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ien <= '0;
      irq <= 1'b0;
    end else begin
      if (wr_ien_set) begin
        ien <= ien | wd[N_EV-1:0];
      end else if (wr_ien_clr) begin
        ien <= ien & ~wd[N_EV-1:0];
      end
      irq <= |(ev & ien);
    end
  end

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  logic [DATA_W-1:0] fast_stat;
  logic [DATA_W-1:0] slow_stat;
  logic [DATA_W-1:0] sel_word;

  assign fast_stat = (DATA_W'(fast_ok_q) << STAT_STATE_BIT) | DATA_W'(fast_ok_q);
  assign slow_stat = (DATA_W'(slow_run) << STAT_STATE_BIT) | DATA_W'(slow_cur);
  assign sel_word = (DATA_W'(slow_external) << SEL_EXT_BIT) |
    (DATA_W'(slow_bypass) << SEL_BYPASS_BIT) | DATA_W'(src_sel);
  // trigger offsets fall through to zero
  assign rd_mux =
    (ar_addr == EV_OFF[EV_FAST]) ? DATA_W'(ev[EV_FAST]) :
    (ar_addr == EV_OFF[EV_SLOW]) ? DATA_W'(ev[EV_SLOW]) :
    (ar_addr == EV_OFF[EV_DONE]) ? DATA_W'(ev[EV_DONE]) :
    (ar_addr == EV_OFF[EV_CT_TIMEOUT]) ? DATA_W'(ev[EV_CT_TIMEOUT]) :
    (ar_addr == OFF_IEN_SET) ? DATA_W'(ien) :
    (ar_addr == OFF_IEN_CLR) ? DATA_W'(ien) :
    (ar_addr == OFF_FAST_RUN) ? DATA_W'(fast_xtal_en) :
    (ar_addr == OFF_FAST_STAT) ? fast_stat :
    (ar_addr == OFF_SLOW_RUN) ? DATA_W'(slow_req) :
    (ar_addr == OFF_SLOW_STAT) ? slow_stat :
    (ar_addr == OFF_SRC_COPY) ? DATA_W'(src_snap) :
    (ar_addr == OFF_SRC_SEL) ? sel_word :
    (ar_addr == OFF_CT_IVL) ? DATA_W'(ct_ivl) :
    '0;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  logic rd_trig;
  assign rd_trig = ar_addr <= OFF_CT_STOP;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  property p_fast_start;
    wr_fast_start |=> fast_xtal_en ##1 fast_xtal_en || $past(wr_fast_stop);
  endproperty
  a_fast_start: assert property (p_fast_start)
    else $error("fast start not held");
  property p_fast_stop;
    wr_fast_stop |=> !fast_xtal_en && s_bvalid;
  endproperty
  a_fast_stop: assert property (p_fast_stop)
    else $error("fast stop not applied");
  property p_snap;
    wr_slow_start |=> src_snap == $past(src_sel) && slow_req;
  endproperty
  a_snap: assert property (p_snap)
    else $error("source snapshot wrong");
  property p_cal;
    wr_cal |=> cal_req;
  endproperty
  a_cal: assert property (p_cal)
    else $error("calibration not requested");
  property p_done;
    cal_req && cal_ack |=> ev[EV_DONE] && !cal_req;
  endproperty
  a_done: assert property (p_done)
    else $error("done event missing");
  property p_ien_set;
    wr_ien_set |=> (ien & $past(wd[N_EV-1:0])) == $past(wd[N_EV-1:0]);
  endproperty
  a_ien_set: assert property (p_ien_set)
    else $error("enable set failed");
  property p_ien_clr;
    wr_ien_clr |=> (ien & $past(wd[N_EV-1:0])) == '0;
  endproperty
  a_ien_clr: assert property (p_ien_clr)
    else $error("enable clear failed");
  property p_irq;
    ##1 irq == $past(|(ev & ien));
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt level wrong");
  property p_trig_rd;
    do_rd && rd_trig |=> s_rvalid && s_rdata == '0;
  endproperty
  a_trig_rd: assert property (p_trig_rd)
    else $error("trigger read not zero");
  property p_slow_run;
    wr_slow_start ##1 !wr_slow_stop |=> slow_req;
  endproperty
  a_slow_run: assert property (p_slow_run)
    else $error("slow run indicator lost");
endmodule
`default_nettype wire

// ### tb/cscr_regs_tb.sv
// self-checking bench for the clock source control register block
`timescale 1ns/1ps
`default_nettype none
module cscr_regs_tb
  import cscr_pkg::*;
();
  // ----------------------------------------
  // signals and design
  // ----------------------------------------
  logic clk = 1'h0;
  logic nrst = 1'h0;
  logic [ADDR_W-1:0] s_awaddr = 12'h0, s_araddr = 12'h0;
  logic [DATA_W-1:0] s_wdata = 32'h0, s_rdata;
  logic [3:0] s_wstrb = 4'hF;
  logic s_awvalid = 1'h0, s_wvalid = 1'h0, s_bready = 1'h0, s_arvalid = 1'h0, s_rready = 1'h0;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
  logic [1:0] s_bresp, s_rresp;
  logic fast_xtal_ok = 1'h0, slow_xtal_ok = 1'h0, cal_ack = 1'h0;
  logic fast_xtal_en, slow_rc_en, slow_xtal_en, slow_synth_en, slow_bypass, slow_external;
  logic cal_req, irq;
  int fail_count = 0;
  int cmp_count = 0;
  logic [1:0] b_last;
  typedef struct {logic w; logic [ADDR_W-1:0] wa; logic [DATA_W-1:0] wd;
    logic [ADDR_W-1:0] ra; logic [DATA_W-1:0] e; logic [1:0] r;} cscr_row_s;
  cscr_row_s rows [12] = '{
    '{1'h0, 12'h0, 32'h0, OFF_FAST_RUN, 32'h0, RESP_OKAY},
    '{1'h0, 12'h0, 32'h0, OFF_SLOW_RUN, 32'h0, RESP_OKAY},
    '{1'h0, 12'h0, 32'h0, OFF_SRC_COPY, 32'h0, RESP_OKAY},
    '{1'h0, 12'h0, 32'h0, OFF_IEN_SET, 32'h0, RESP_OKAY},
    '{1'h0, 12'h0, 32'h0, EV_OFF[EV_CT_TIMEOUT], 32'h0, RESP_OKAY},
    '{1'h1, OFF_FAST_START, 32'h0, OFF_FAST_RUN, 32'h0, RESP_OKAY},
    '{1'h1, OFF_FAST_START, 32'h1, OFF_FAST_START, 32'h0, RESP_OKAY},
    '{1'h0, 12'h0, 32'h0, OFF_FAST_RUN, 32'h1, RESP_OKAY},
    '{1'h1, OFF_SRC_SEL, 32'h2, OFF_SRC_SEL, 32'h2, RESP_OKAY},
    '{1'h1, OFF_SRC_SEL, 32'h30001, OFF_SRC_SEL, 32'h30001, RESP_OKAY},
    '{1'h1, OFF_SLOW_RUN, 32'h1, OFF_SLOW_RUN, 32'h0, RESP_OKAY},
    '{1'h1, 12'h600, 32'h1, 12'h600, 32'h0, RESP_SLVERR}};

  cscr_regs #(.CT_UNIT_CYCLES(4)) uut (.clk, .nrst, .s_awaddr, .s_awvalid, .s_awready,
    .s_wdata, .s_wstrb, .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr,
    .s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready, .fast_xtal_ok,
    .slow_xtal_ok, .cal_ack, .fast_xtal_en, .slow_rc_en, .slow_xtal_en, .slow_synth_en,
    .slow_bypass, .slow_external, .cal_req, .irq);

  always #10 clk = ~clk;

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic finish_test();
    if (fail_count == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic hang();
    fail_count++;
    $display("MISMATCH %0t bus wait ran out", $time);
    finish_test();
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    int n;
    @(posedge clk);
    n = 0;
    s_awaddr <= a;
    s_wdata <= d;
    s_awvalid <= 1'h1;
    s_wvalid <= 1'h1;
    s_bready <= 1'h1;
    do begin
      @(posedge clk);
      if (s_awready) s_awvalid <= 1'h0;
      if (s_wready) s_wvalid <= 1'h0;
      if (++n > 50) hang();
    end while (!s_bvalid);
    b_last = s_bresp;
    s_bready <= 1'h0;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d,
    output logic [1:0] r);
    int n;
    @(posedge clk);
    n = 0;
    s_araddr <= a;
    s_arvalid <= 1'h1;
    s_rready <= 1'h1;
    do begin
      @(posedge clk);
      if (s_arready) s_arvalid <= 1'h0;
      if (++n > 50) hang();
    end while (!s_rvalid);
    d = s_rdata;
    r = s_rresp;
    s_rready <= 1'h0;
  endtask

  task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    logic [DATA_W-1:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(d, e);
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    logic [DATA_W-1:0] d;
    logic [1:0] r;
    tick(10);
    nrst <= 1'h1;
    tick(3);
    foreach (rows[i]) begin
      if (rows[i].w) wr(rows[i].wa, rows[i].wd);
      rd(rows[i].ra, d, r);
      chk(d, rows[i].e);
      chk({30'h0, r}, {30'h0, rows[i].r});
      if (rows[i].w) chk({30'h0, b_last}, {30'h0, rows[i].r});
    end
    // fast crystal comes up with its interrupt enabled
    wr(OFF_IEN_SET, 32'h1);
    fast_xtal_ok <= 1'h1;
    tick(4);
    chk({31'h0, irq}, 32'h1);
    rdchk(OFF_IEN_CLR, 32'h1);
    wr(OFF_IEN_CLR, 32'h1);
    tick(3);
    chk({31'h0, irq}, 32'h0);
    wr(OFF_IEN_SET, 32'h0);
    rdchk(OFF_IEN_SET, 32'h0);
    rdchk(EV_OFF[EV_FAST], 32'h1);
    wr(OFF_FAST_STOP, 32'h1);
    tick(2);
    chk({31'h0, fast_xtal_en}, 32'h0);
    // slow clock on external rail-to-rail source
    chk({30'h0, slow_external, slow_bypass}, 32'h3);
    wr(OFF_SLOW_START, 32'h1);
    rdchk(OFF_SLOW_RUN, 32'h1);
    rdchk(OFF_SRC_COPY, 32'h1);
    chk({31'h0, slow_rc_en}, 32'h1);
    rdchk(EV_OFF[EV_SLOW], 32'h0);
    slow_xtal_ok <= 1'h1;
    tick(4);
    chk({30'h0, slow_xtal_en, slow_rc_en}, 32'h2);
    rdchk(EV_OFF[EV_SLOW], 32'h1);
    rdchk(OFF_SLOW_STAT, 32'h10001);
    wr(OFF_SLOW_STOP, 32'h1);
    rdchk(OFF_SLOW_STAT, 32'h1);
    // rc calibration
    wr(OFF_CAL, 32'h1);
    chk({31'h0, cal_req}, 32'h1);
    cal_ack <= 1'h1;
    tick(2);
    cal_ack <= 1'h0;
    tick(2);
    chk({31'h0, cal_req}, 32'h0);
    rdchk(EV_OFF[EV_DONE], 32'h1);
    // calibration timer, two units of four clocks
    wr(OFF_CT_IVL, 32'h2);
    wr(OFF_CT_START, 32'h1);
    rdchk(EV_OFF[EV_CT_TIMEOUT], 32'h0);
    tick(20);
    rdchk(EV_OFF[EV_CT_TIMEOUT], 32'h1);
    tick(20);
    rdchk(EV_OFF[EV_CT_TIMEOUT], 32'h0);
    wr(OFF_CT_START, 32'h1);
    wr(OFF_CT_STOP, 32'h1);
    tick(20);
    rdchk(EV_OFF[EV_CT_TIMEOUT], 32'h0);
    // reset with every clock and the timer stopped
    nrst <= 1'h0;
    tick(2);
    nrst <= 1'h1;
    tick(3);
    rdchk(OFF_SRC_SEL, 32'h0);
    // slow clock from the synthesizer starts at once
    wr(OFF_SRC_SEL, 32'h2);
    wr(OFF_SLOW_START, 32'h1);
    tick(2);
    chk({31'h0, slow_synth_en}, 32'h1);
    rdchk(EV_OFF[EV_SLOW], 32'h1);
    rdchk(OFF_SLOW_STAT, 32'h10002);
    rdchk(OFF_SRC_COPY, 32'h2);
    finish_test();
  end
endmodule
`default_nettype wire
